/* logic/occ_pkg.sv */
// Constants and types shared by the output compare channel files
package occ_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 3;
  // Register addresses
  localparam logic [2:0] ADDR_CTRL_ONE = 3'h0;
  localparam logic [2:0] ADDR_CTRL_TWO = 3'h1;
  localparam logic [2:0] ADDR_PRI_CMP = 3'h2;
  localparam logic [2:0] ADDR_SEC_CMP = 3'h3;
  localparam logic [2:0] ADDR_PERIOD = 3'h4;
  localparam logic [2:0] ADDR_TIMER = 3'h5;
  // Reset values
  localparam logic [15:0] CTRL_ONE_RST = 16'h0000;
  localparam logic [15:0] CTRL_TWO_RST = 16'h000C;
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;
  // Control one fields
  localparam int C1_MODE_LSB = 0;
  localparam int C1_AUTOCLR = 3;
  localparam int C1_FSTAT_LSB = 4;
  localparam int C1_FEN_LSB = 7;
  localparam int C1_TSEL_LSB = 10;
  localparam int C1_IDLE_STOP = 13;
  localparam logic [15:0] C1_WMASK = 16'h3FFF;
  // Control two fields
  localparam int C2_SYNC_LSB = 0;
  localparam int C2_TRIS = 5;
  localparam int C2_TRIG_RUN = 6;
  localparam int C2_TRIG_NOT_SYNC = 7;
  localparam int C2_CASCADE = 8;
  localparam int C2_DCB_LSB = 9;
  localparam int C2_INVERT = 12;
  localparam int C2_FLT_TRIS = 13;
  localparam int C2_FLT_LEVEL = 14;
  localparam int C2_FLT_HOLD = 15;
  localparam logic [15:0] C2_WMASK = 16'hF7FF;
  localparam int FAULT_N = 3;
  // Channel modes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_SS_HIGH = 3'h1;
  localparam logic [2:0] MODE_SS_LOW = 3'h2;
  localparam logic [2:0] MODE_TOGGLE = 3'h3;
  localparam logic [2:0] MODE_DBL_ONE = 3'h4;
  localparam logic [2:0] MODE_DBL_CONT = 3'h5;
  localparam logic [2:0] MODE_PWM_EDGE = 3'h6;
  localparam logic [2:0] MODE_PWM_CTR = 3'h7;
  // Timer clock select codes
  localparam logic [2:0] TSEL_TMR1 = 3'h4;
  localparam logic [2:0] TSEL_PCLK = 3'h7;
  // Source select codes
  localparam logic [4:0] SRC_NONE = 5'h00;
  localparam logic [4:0] SRC_RSVD_A = 5'h10;
  localparam logic [4:0] SRC_RSVD_B = 5'h11;
  localparam logic [4:0] SRC_SELF = 5'h1F;
  // Sequencing for the compare modes, Gray along the usual path
  typedef enum logic [1:0] {
    OCC_IDLE = 2'b00,
    OCC_ARMED = 2'b01,
    OCC_ACTIVE = 2'b11,
    OCC_DONE = 2'b10
  } occ_state_t;
endpackage

/* logic/occ_channel_timer.sv */
// Channel timer with period wrap, hold-clear and sync restart
`timescale 1ns/1ps
`default_nettype none
module occ_channel_timer (
  input wire logic core_clk, // Clock
  input wire logic srst, // Synchronous reset
  input wire logic ce, // Clock enable
  input wire logic tick, // Count enable from selected clock
  input wire logic hold_clear, // Keep count at zero
  input wire logic restart, // Sync event, restart count
  input wire logic [15:0] period, // Wrap value
  output logic [15:0] count, // Current count
  output logic stepped, // Count changed this cycle
  output logic wrap // Period completed
);
  wire logic at_period;
  wire logic [15:0] next_count;

  assign at_period = (count == period);
  assign next_count = (hold_clear || restart || at_period) ? 16'h0000 : count + 16'h0001;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      count <= 16'h0000;
      stepped <= 1'b0;
      wrap <= 1'b0;
    end else if (ce) begin
      stepped <= 1'b0;
      wrap <= 1'b0;
      if (hold_clear || restart) begin
        count <= 16'h0000;
      end else if (tick) begin
        count <= next_count;
        stepped <= 1'b1;
        wrap <= at_period;
      end
    end
  end
endmodule // occ_channel_timer
`default_nettype wire

/* logic/occ_channel_ctrl.sv */
// Output compare channel control: registers, modes, faults, trigger
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module occ_channel_ctrl (
  input wire logic core_clk, // Clock, 50 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic [2:0] addr, // Register address
  input wire logic [15:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [15:0] rdata, // Read data, cycle after strobe
  input wire logic [4:0] timer_ticks, // Timer 1..5 prescaler ticks
  input wire logic [31:0] source_events, // Trigger or sync events by code
  input wire logic [2:0] fault_inputs, // Fault 0 is fault pin A
  input wire logic cascade_carry_in, // Wrap pulse of the lower channel
  output logic cascade_carry_out, // Wrap pulse for the upper channel
  output logic compare_output, // Pin output level
  output logic compare_output_oe, // Pin drive enable
  output logic [1:0] fall_delay, // Falling edge fraction for pad delay
  output logic period_event // Own period completed
);
  function automatic logic pick_source(input logic [4:0] code, input logic [31:0] ev,
                                       input logic self_ev);
    logic hit;
    hit = 1'b0;
    if (code == occ_pkg::SRC_SELF) begin
      hit = self_ev;
    end else if (code != occ_pkg::SRC_NONE && code != occ_pkg::SRC_RSVD_A &&
                 code != occ_pkg::SRC_RSVD_B) begin
      hit = ev[code];
    end
    return hit;
  endfunction

  function automatic logic pick_tick(input logic [2:0] sel, input logic [4:0] ticks);
    logic t;
    t = 1'b0;
    if (sel < occ_pkg::TSEL_TMR1) begin
      // Codes 000 to 011 pick timers 2 to 5, held in tick bits 1 to 4
      t = ticks[{1'b0, sel[1:0]} + 3'd1];
    end else if (sel == occ_pkg::TSEL_TMR1) begin
      t = ticks[0];
    end else if (sel == occ_pkg::TSEL_PCLK) begin
      t = 1'b1;
    end
    return t;
  endfunction

  logic [15:0] ctrl_one;
  logic [15:0] ctrl_two;
  logic [15:0] primary_compare_value;
  logic [15:0] secondary_compare_value;
  logic [15:0] period_register;
  logic [15:0] pri_act;
  logic [15:0] sec_act;
  logic [1:0] dcb_act;
  logic [2:0] last_mode;
  logic out_level;
  logic fault_active;
  occ_pkg::occ_state_t state;
  occ_pkg::occ_state_t next_state;
  logic next_level;

  wire logic [15:0] channel_timer;
  wire logic stepped;
  wire logic wrap;
  wire logic [2:0] channel_mode_field;
  wire logic trig_flag_autoclear_mode;
  wire logic [2:0] fault_input_enables;
  wire logic [2:0] fault_status;
  wire logic [2:0] timer_clock_select;
  wire logic [4:0] source_select_field;
  wire logic pin_tristate;
  wire logic trigger_run_flag;
  wire logic trigger_not_sync;
  wire logic cascade_enable;
  wire logic [1:0] duty_fraction_bits;
  wire logic output_invert;
  wire logic fault_tristate_enable;
  wire logic fault_level;
  wire logic fault_hold_select;
  wire logic pwm_mode;
  wire logic mode_changed;
  wire logic wr_one;
  wire logic wr_two;
  wire logic src_event;
  wire logic tick_sel;
  wire logic timer_tick;
  wire logic hold_clear;
  wire logic sync_restart;
  wire logic match_pri;
  wire logic match_sec;
  wire logic pwm_level;
  wire logic [2:0] fault_hit;
  wire logic [2:0] next_fault_status;
  wire logic fault_source;
  wire logic fault_exit;
  wire logic trig_set;
  wire logic trig_clr;
  wire logic next_trig_run;
  wire logic drive_level;
  wire logic next_oe;
  wire logic [15:0] next_rdata;

  assign channel_mode_field = ctrl_one[occ_pkg::C1_MODE_LSB +: 3];
  assign trig_flag_autoclear_mode = ctrl_one[occ_pkg::C1_AUTOCLR];
  assign fault_status = ctrl_one[occ_pkg::C1_FSTAT_LSB +: 3];
  assign fault_input_enables = ctrl_one[occ_pkg::C1_FEN_LSB +: 3];
  assign timer_clock_select = ctrl_one[occ_pkg::C1_TSEL_LSB +: 3];
  assign source_select_field = ctrl_two[occ_pkg::C2_SYNC_LSB +: 5];
  assign pin_tristate = ctrl_two[occ_pkg::C2_TRIS];
  assign trigger_run_flag = ctrl_two[occ_pkg::C2_TRIG_RUN];
  assign trigger_not_sync = ctrl_two[occ_pkg::C2_TRIG_NOT_SYNC];
  assign cascade_enable = ctrl_two[occ_pkg::C2_CASCADE];
  assign duty_fraction_bits = ctrl_two[occ_pkg::C2_DCB_LSB +: 2];
  assign output_invert = ctrl_two[occ_pkg::C2_INVERT];
  assign fault_tristate_enable = ctrl_two[occ_pkg::C2_FLT_TRIS];
  assign fault_level = ctrl_two[occ_pkg::C2_FLT_LEVEL];
  assign fault_hold_select = ctrl_two[occ_pkg::C2_FLT_HOLD];

  assign pwm_mode = (channel_mode_field == occ_pkg::MODE_PWM_EDGE) ||
                    (channel_mode_field == occ_pkg::MODE_PWM_CTR);
  assign mode_changed = (channel_mode_field != last_mode);
  assign wr_one = wr && (addr == occ_pkg::ADDR_CTRL_ONE);
  assign wr_two = wr && (addr == occ_pkg::ADDR_CTRL_TWO);

  // Clock and source selection
  assign tick_sel = pick_tick(timer_clock_select, timer_ticks);
  // Upper half of a cascaded pair counts on the lower half's wrap
  assign timer_tick = cascade_enable ? cascade_carry_in : tick_sel;
  assign src_event = pick_source(source_select_field, source_events, wrap);
  // Self-selection loops through own wrap; software keeps clear of it
  assign trig_set = trigger_not_sync && src_event;
  assign hold_clear = (channel_mode_field == occ_pkg::MODE_OFF) ||
                      (trigger_not_sync && !trigger_run_flag && !trig_set);
  assign sync_restart = !trigger_not_sync && src_event;

  occ_channel_timer u_timer (
    .core_clk(core_clk),
    .srst(srst),
    .ce(ce),
    .tick(timer_tick),
    .hold_clear(hold_clear),
    .restart(sync_restart),
    .period(period_register),
    .count(channel_timer),
    .stepped(stepped),
    .wrap(wrap)
  );

  assign match_pri = stepped && (channel_timer == pri_act);
  assign match_sec = stepped && (channel_timer == sec_act);

  // Trigger run flag: hardware set wins over any clear
  assign trig_clr = (wr_two && !wdata[occ_pkg::C2_TRIG_RUN]) ||
                    (trig_flag_autoclear_mode && match_sec);
  assign next_trig_run = trig_set || (trigger_run_flag && !trig_clr);

  // Fault capture per input
  genvar gi;
  generate
    for (gi = 0; gi < occ_pkg::FAULT_N; gi++) begin : g_fault
      assign fault_hit[gi] = pwm_mode && fault_input_enables[gi] && fault_inputs[gi];
      assign next_fault_status[gi] = fault_hit[gi] ||
        (fault_status[gi] && !(wr_one && !wdata[occ_pkg::C1_FSTAT_LSB + gi]));
    end
  endgenerate
  assign fault_source = |fault_hit;
  assign fault_exit = !fault_source &&
                      (fault_hold_select ? (fault_status == 3'h0) : wrap);

  // PWM waveform from buffered compare values
  assign pwm_level = (channel_mode_field == occ_pkg::MODE_PWM_CTR) ?
                     ((channel_timer >= pri_act) && (channel_timer < sec_act)) :
                     (channel_timer < sec_act);

  // Compare mode sequencing
  always_comb begin
    next_state = state;
    next_level = out_level;
    if (mode_changed) begin
      // Any write that changes the mode restarts the sequence
      next_level = (channel_mode_field == occ_pkg::MODE_SS_LOW);
      if (channel_mode_field == occ_pkg::MODE_OFF) begin
        next_state = occ_pkg::OCC_IDLE;
      end else begin
        next_state = occ_pkg::OCC_ARMED;
      end
    end else begin
      case (channel_mode_field)
        occ_pkg::MODE_SS_HIGH, occ_pkg::MODE_SS_LOW: begin
          if (state == occ_pkg::OCC_ARMED && match_pri) begin
            next_level = (channel_mode_field == occ_pkg::MODE_SS_HIGH);
            next_state = occ_pkg::OCC_DONE;
          end
        end
        occ_pkg::MODE_TOGGLE: begin
          if (match_pri) begin
            next_level = !out_level;
          end
        end
        occ_pkg::MODE_DBL_ONE, occ_pkg::MODE_DBL_CONT: begin
          if (state == occ_pkg::OCC_ARMED && match_pri) begin
            next_level = !out_level;
            next_state = occ_pkg::OCC_ACTIVE;
          end else if (state == occ_pkg::OCC_ACTIVE && match_sec) begin
            next_level = !out_level;
            if (channel_mode_field == occ_pkg::MODE_DBL_CONT) begin
              next_state = occ_pkg::OCC_ARMED;
            end else begin
              next_state = occ_pkg::OCC_DONE;
            end
          end
        end
        occ_pkg::MODE_PWM_EDGE, occ_pkg::MODE_PWM_CTR: begin
          next_level = pwm_level;
          next_state = occ_pkg::OCC_ACTIVE;
        end
        default: begin
          next_level = 1'b0;
          next_state = occ_pkg::OCC_IDLE;
        end
      endcase
    end
  end

  // Disabled channel parks the pin low, whatever the invert bit says
  assign drive_level = (channel_mode_field == occ_pkg::MODE_OFF) ? 1'b0 :
                       fault_active ? fault_level :
                       (out_level ^ output_invert);
  assign next_oe = (!pin_tristate || (fault_active && fault_tristate_enable)) &&
                   (channel_mode_field != occ_pkg::MODE_OFF);

  assign next_rdata =
    (addr == occ_pkg::ADDR_CTRL_ONE) ? ctrl_one :
    (addr == occ_pkg::ADDR_CTRL_TWO) ? ctrl_two :
    (addr == occ_pkg::ADDR_PRI_CMP) ? primary_compare_value :
    (addr == occ_pkg::ADDR_SEC_CMP) ? secondary_compare_value :
    (addr == occ_pkg::ADDR_PERIOD) ? period_register :
    (addr == occ_pkg::ADDR_TIMER) ? channel_timer : 16'h0000;

  // Register file
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_one <= occ_pkg::CTRL_ONE_RST;
      ctrl_two <= occ_pkg::CTRL_TWO_RST;
      primary_compare_value <= 16'h0000;
      secondary_compare_value <= 16'h0000;
      period_register <= occ_pkg::PERIOD_RST;
      rdata <= 16'h0000;
    end else if (ce) begin
      rdata <= rd ? next_rdata : 16'h0000;
      if (wr_one) begin
        ctrl_one <= wdata & occ_pkg::C1_WMASK;
      end
      ctrl_one[occ_pkg::C1_FSTAT_LSB +: 3] <= next_fault_status;
      if (wr_two) begin
        ctrl_two <= wdata & occ_pkg::C2_WMASK;
      end
      ctrl_two[occ_pkg::C2_TRIG_RUN] <= next_trig_run;
      if (wr && addr == occ_pkg::ADDR_PRI_CMP) begin
        primary_compare_value <= wdata;
      end
      if (wr && addr == occ_pkg::ADDR_SEC_CMP) begin
        secondary_compare_value <= wdata;
      end
      if (wr && addr == occ_pkg::ADDR_PERIOD) begin
        period_register <= wdata;
      end
    end
  end

  // Duty buffers: latched at period end in PWM, transparent otherwise
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pri_act <= 16'h0000;
      sec_act <= 16'h0000;
      dcb_act <= 2'h0;
    end else if (ce && (!pwm_mode || wrap)) begin
      pri_act <= primary_compare_value;
      sec_act <= secondary_compare_value;
      dcb_act <= duty_fraction_bits;
    end
  end

  // Channel sequencing, fault state and pin outputs
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= occ_pkg::OCC_IDLE;
      out_level <= 1'b0;
      last_mode <= occ_pkg::MODE_OFF;
      fault_active <= 1'b0;
      compare_output <= 1'b0;
      compare_output_oe <= 1'b0;
      fall_delay <= 2'h0;
      cascade_carry_out <= 1'b0;
      period_event <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      out_level <= next_level;
      last_mode <= channel_mode_field;
      if (!pwm_mode) begin
        fault_active <= 1'b0;
      end else if (fault_source) begin
        fault_active <= 1'b1;
      end else if (fault_exit) begin
        fault_active <= 1'b0;
      end
      compare_output <= drive_level;
      compare_output_oe <= next_oe;
      fall_delay <= pwm_mode ? dcb_act : duty_fraction_bits;
      cascade_carry_out <= wrap;
      period_event <= wrap;
    end
  end
endmodule // occ_channel_ctrl
`default_nettype wire

/* test/occ_channel_ctrl_sva.sv */
// Port-level checks for the output compare channel control
`timescale 1ns/1ps
`default_nettype none
module occ_channel_ctrl_sva (
  input wire logic core_clk, // Clock
  input wire logic srst, // Reset
  input wire logic ce, // Enable
  input wire logic [2:0] addr, // Address
  input wire logic [15:0] wdata, // Write data
  input wire logic wr, // Write
  input wire logic rd, // Read
  input wire logic [15:0] rdata, // Read data
  input wire logic cascade_carry_out, // Carry out
  input wire logic compare_output, // Pin level
  input wire logic compare_output_oe, // Pin enable
  input wire logic [1:0] fall_delay, // Fraction
  input wire logic period_event // Wrap pulse
);
  logic [2:0] mode_q;
  logic tris_q;
  logic inv_q;
  logic [1:0] dcb_q;
  wire w1 = wr && ce && addr == occ_pkg::ADDR_CTRL_ONE;
  wire w2 = wr && ce && addr == occ_pkg::ADDR_CTRL_TWO;
  wire pwm_q = mode_q[2] && mode_q[1];
  // Shadow of fields software wrote
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode_q <= 3'h0;
      tris_q <= 1'b0;
      inv_q <= 1'b0;
      dcb_q <= 2'h0;
    end else begin
      if (w1) mode_q <= wdata[2:0];
      if (w2) tris_q <= wdata[5];
      if (w2) inv_q <= wdata[12];
      if (w2) dcb_q <= wdata[10:9];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  rdata_idle_a: assert property ($past(ce) && !$past(rd) |-> rdata == 16'h0000)
    else $error("read data not zero outside a read");
  unmapped_zero_a: assert property ($past(rd && ce && addr > 3'h5) |-> rdata == 16'h0000)
    else $error("unmapped read not zero");
  c1_rsvd_a: assert property ($past(rd && ce && addr == 3'h0) |-> rdata[15:14] == 2'h0)
    else $error("control one top bits not zero");
  c2_rsvd_a: assert property ($past(rd && ce && addr == 3'h1) |-> !rdata[11])
    else $error("control two bit 11 not zero");
  wrap_pair_a: assert property (period_event == cascade_carry_out)
    else $error("carry out differs from period event");
  off_quiet_a: assert property (mode_q == 3'h0 && $past(mode_q) == 3'h0
    |-> !compare_output_oe && !compare_output)
    else $error("disabled channel drives pin");
  drive_on_a: assert property (mode_q != 3'h0 && $past(mode_q) != 3'h0 && !tris_q
    && !$past(tris_q) |-> compare_output_oe)
    else $error("connected pin not driven");
  fall_follow_a: assert property (!pwm_q && !$past(pwm_q) && dcb_q == $past(dcb_q)
    |-> fall_delay == dcb_q)
    else $error("fall delay differs from fraction bits");
  init_high_a: assert property (w1 && wdata[2:0] == 3'h2 && mode_q != 3'h2 && !inv_q
    |-> ##[1:3] compare_output)
    else $error("mode 010 did not start high");
  init_low_a: assert property (w1 && wdata[2:0] inside {3'h1, 3'h4, 3'h5}
    && mode_q != wdata[2:0] && !inv_q |-> ##[1:3] !compare_output)
    else $error("mode did not start low");
endmodule // occ_channel_ctrl_sva
bind occ_channel_ctrl occ_channel_ctrl_sva u_sva (.core_clk(core_clk), .srst(srst), .ce(ce),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .cascade_carry_out(cascade_carry_out), .compare_output(compare_output),
  .compare_output_oe(compare_output_oe), .fall_delay(fall_delay), .period_event(period_event));
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the output compare channel control
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [4:0] timer_ticks = 5'h1F;
  logic [31:0] source_events = 32'h0;
  logic [2:0] fault_inputs = 3'h0;
  logic cascade_carry_in = 1'b0;
  wire logic [15:0] rdata;
  wire logic carry_out;
  wire logic out;
  wire logic oe;
  wire logic [1:0] fall_delay;
  wire logic period_event;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  occ_channel_ctrl dut (.core_clk(core_clk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .timer_ticks(timer_ticks), .source_events(source_events),
    .fault_inputs(fault_inputs), .cascade_carry_in(cascade_carry_in),
    .cascade_carry_out(carry_out), .compare_output(out), .compare_output_oe(oe),
    .fall_delay(fall_delay), .period_event(period_event));
  always #10 core_clk = ~core_clk;
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic chk_rd(input string nm, input logic [2:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 chk(nm, exp, rdata);
  endtask
  task automatic pulse_src(input int code);
    @(posedge core_clk);
    source_events <= 32'h1 << code;
    @(posedge core_clk);
    source_events <= 32'h0;
  endtask
  task automatic t_regs();
    chk_rd("ctrl_one rst", 3'h0, occ_pkg::CTRL_ONE_RST);
    chk_rd("ctrl_two rst", 3'h1, occ_pkg::CTRL_TWO_RST);
    chk_rd("period rst", 3'h4, occ_pkg::PERIOD_RST);
    wr_reg(3'h6, 16'hA5A5);
    chk_rd("unmapped", 3'h6, 16'h0000);
    wr_reg(3'h0, 16'hFFFF);
    wr_reg(3'h1, 16'hFFFF);
    chk_rd("ctrl_one mask", 3'h0, 16'h3F8F);
    chk_rd("ctrl_two mask", 3'h1, 16'hF7BF);
    wr_reg(3'h0, 16'h0000);
    wr_reg(3'h1, 16'h0000);
    $display("test regs done");
  endtask
  // Edges and high cycles over 60 cycles after a mode write
  task automatic run_mode(input logic [15:0] c2, input logic [2:0] m, input int r,
                          input int f, input int h);
    int nr;
    int nf;
    int nh;
    int np;
    int nc;
    logic prev;
    nr = 0;
    nf = 0;
    nh = 0;
    np = 0;
    nc = 0;
    wr_reg(3'h0, 16'h1C00);
    wr_reg(3'h1, c2);
    idle(2);
    #1;
    chk("off oe", 16'h0000, {15'h0, oe});
    chk("off level", 16'h0000, {15'h0, out});
    prev = out;
    wr_reg(3'h0, 16'h1C00 | {13'h0, m});
    repeat (60) begin
      @(posedge core_clk);
      #1;
      if (out && !prev) nr++;
      if (!out && prev) nf++;
      if (out) nh++;
      if (period_event) np++;
      if (carry_out) nc++;
      prev = out;
    end
    chk("rises", 16'(r), 16'(nr));
    chk("falls", 16'(f), 16'(nf));
    if (h >= 0) chk("high cycles", 16'(h), 16'(nh));
    chk("period events", 16'h0002, 16'(np));
    chk("carry pulses", 16'h0002, 16'(nc));
    chk("oe", 16'h0001, {15'h0, oe});
    chk("fall_delay", {14'h0, c2[10:9]}, {14'h0, fall_delay});
    $display("test mode %0d done", m);
  endtask
  task automatic t_fault();
    wr_reg(3'h0, 16'h1C81);
    wr_reg(3'h1, 16'hE020);
    fault_inputs <= 3'h1;
    idle(4);
    chk_rd("status outside pwm", 3'h0, 16'h1C81);
    chk("oe outside pwm", 16'h0000, {15'h0, oe});
    wr_reg(3'h0, 16'h1C86);
    idle(3);
    #1;
    chk("fault oe", 16'h0001, {15'h0, oe});
    chk("fault level", 16'h0001, {15'h0, out});
    chk_rd("fault a status", 3'h0, 16'h1C96);
    fault_inputs <= 3'h0;
    idle(30);
    #1;
    chk("hold until clear", 16'h0001, {15'h0, oe});
    wr_reg(3'h0, 16'h1C86);
    idle(3);
    #1;
    chk("released", 16'h0000, {15'h0, oe});
    wr_reg(3'h1, 16'h6020);
    fault_inputs <= 3'h1;
    idle(3);
    fault_inputs <= 3'h0;
    idle(25);
    #1;
    chk("new period exit", 16'h0000, {15'h0, oe});
    wr_reg(3'h0, 16'h1C00);
    $display("test fault done");
  endtask
  task automatic t_trig();
    wr_reg(3'h1, 16'h008B);
    wr_reg(3'h0, 16'h1C09);
    idle(5);
    chk_rd("held timer", 3'h5, 16'h0000);
    chk_rd("flag idle", 3'h1, 16'h008B);
    pulse_src(11);
    chk_rd("flag set", 3'h1, 16'h00CB);
    idle(12);
    chk_rd("autoclear", 3'h1, 16'h008B);
    wr_reg(3'h0, 16'h1C01);
    pulse_src(11);
    idle(30);
    chk_rd("no autoclear", 3'h1, 16'h00CB);
    wr_reg(3'h1, 16'h008B);
    chk_rd("sw clear", 3'h1, 16'h008B);
    wr_reg(3'h1, 16'h0090);
    pulse_src(16);
    chk_rd("reserved code", 3'h1, 16'h0090);
    wr_reg(3'h0, 16'h1C00);
    $display("test trigger done");
  endtask
  task automatic t_casc();
    wr_reg(3'h1, 16'h0100);
    wr_reg(3'h0, 16'h1C01);
    idle(4);
    chk_rd("cascade held", 3'h5, 16'h0000);
    repeat (3) begin
      @(posedge core_clk);
      cascade_carry_in <= 1'b1;
      @(posedge core_clk);
      cascade_carry_in <= 1'b0;
    end
    idle(2);
    chk_rd("cascade count", 3'h5, 16'h0003);
    // Carry pulse while the enable is low must not count
    @(posedge core_clk);
    ce <= 1'b0;
    cascade_carry_in <= 1'b1;
    @(posedge core_clk);
    cascade_carry_in <= 1'b0;
    @(posedge core_clk);
    ce <= 1'b1;
    chk_rd("frozen count", 3'h5, 16'h0003);
    $display("test cascade done");
  endtask
  task automatic t_tsel();
    timer_ticks <= 5'h0F;
    wr_reg(3'h1, 16'h0000);
    wr_reg(3'h0, 16'h0C01);
    idle(4);
    chk_rd("timer5 idle", 3'h5, 16'h0000);
    wr_reg(3'h0, 16'h1001);
    idle(3);
    chk_rd("timer1 runs", 3'h5, 16'h0004);
    wr_reg(3'h0, 16'h1C00);
    timer_ticks <= 5'h1F;
    $display("test tsel done");
  endtask
  initial begin
    idle(3);
    srst <= 1'b0;
    t_regs();
    wr_reg(3'h4, 16'h0014);
    wr_reg(3'h2, 16'h0003);
    wr_reg(3'h3, 16'h0008);
    run_mode(16'h0000, 3'h1, 1, 0, -1);
    run_mode(16'h0200, 3'h2, 1, 1, -1);
    run_mode(16'h0400, 3'h3, 2, 1, -1);
    run_mode(16'h0600, 3'h4, 1, 1, 5);
    run_mode(16'h0200, 3'h5, 3, 3, 15);
    run_mode(16'h0400, 3'h6, 3, 3, -1);
    run_mode(16'h0600, 3'h7, 3, 3, 15);
    run_mode(16'h1000, 3'h1, 1, 1, -1);
    t_fault();
    t_trig();
    t_tsel();
    t_casc();
    end_sim();
  end
endmodule // tb
`default_nettype wire
